// file: pkg/lprr_pkg.sv
// Package: register map, field layout, reset values and timing for portrait rotation refresh.
// Assumes a byte-wide register port and a single 125 MHz system clock.
package lprr_pkg;
    localparam int unsigned LPRR_ADDR_W = 8;
    localparam int unsigned LPRR_DATA_W = 8;
    localparam int unsigned LPRR_MADDR_W = 17;
    // Register offsets
    localparam logic [7:0] LPRR_OFS_START_LO = 8'h0C;
    localparam logic [7:0] LPRR_OFS_START_MID = 8'h0D;
    localparam logic [7:0] LPRR_OFS_START_TOP = 8'h0E;
    localparam logic [7:0] LPRR_OFS_ROT_CTRL = 8'h1B;
    localparam logic [7:0] LPRR_OFS_STRIDE = 8'h1C;
    // Rotation control fields
    localparam int unsigned LPRR_BIT_ENABLE = 7;
    localparam int unsigned LPRR_BIT_ALT = 6;
    localparam int unsigned LPRR_BIT_MCLK_SEL = 2;
    localparam int unsigned LPRR_BIT_PCLK_HI = 1;
    localparam int unsigned LPRR_BIT_PCLK_LO = 0;
    localparam logic [7:0] LPRR_CTRL_MASK = 8'hC7;
    // Reset values
    localparam logic [7:0] LPRR_RST_START_LO = 8'h00;
    localparam logic [7:0] LPRR_RST_START_MID = 8'h00;
    localparam logic [7:0] LPRR_RST_START_TOP = 8'h00;
    localparam logic [7:0] LPRR_RST_ROT_CTRL = 8'h00;
    localparam logic [7:0] LPRR_RST_STRIDE = 8'h00;
    // Panel geometry defaults (landscape panel, portrait image)
    localparam int unsigned LPRR_PANEL_COLS = 320;
    localparam int unsigned LPRR_PANEL_ROWS = 240;
    localparam int unsigned LPRR_DEFAULT_WIDTH = 256;
    // Memory clock boost hold after a CPU access, in ns and cycles
    localparam int unsigned LPRR_CLK_MHZ = 125;
    localparam int unsigned LPRR_BOOST_HOLD_NS = 16;
    localparam int unsigned LPRR_BOOST_HOLD_CYC =
        (LPRR_BOOST_HOLD_NS * LPRR_CLK_MHZ + 999) / 1000;
endpackage

// file: pkg/lprr_shadow_if.sv
// Interface: live register values handed to the frame shadow.
// Assumes one clock domain; the shadow module latches on frame start.
`timescale 1ns/1ps
`default_nettype none
interface lprr_shadow_if;
    logic frame_start;
    logic [16:0] live_start;
    logic [7:0] live_ctrl;
    logic [7:0] live_stride;
    logic [16:0] act_start;
    logic [7:0] act_ctrl;
    logic [7:0] act_stride;
    modport src (output frame_start, live_start, live_ctrl, live_stride, input act_start, act_ctrl, act_stride);
    modport dst (input frame_start, live_start, live_ctrl, live_stride, output act_start, act_ctrl, act_stride);
endinterface
`default_nettype wire

// file: logic/lprr_shadow.sv
// Frame shadow: active copy of start, control and stride taken at frame start.
// Assumes frame_start is a one-cycle pulse from the refresh scan.
`timescale 1ns/1ps
`default_nettype none
module lprr_shadow (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_ce,
    // Values
    lprr_shadow_if.dst sh
);
    import lprr_pkg::*;
    logic [16:0] start_q, start_d;
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] stride_q, stride_d;
    always_comb begin
        start_d = start_q;
        ctrl_d = ctrl_q;
        stride_d = stride_q;
        if (sh.frame_start) begin
            start_d = sh.live_start;
            ctrl_d = sh.live_ctrl;
            stride_d = sh.live_stride;
        end
    end
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            start_q <= {LPRR_RST_START_TOP[0], LPRR_RST_START_MID, LPRR_RST_START_LO};
            ctrl_q <= LPRR_RST_ROT_CTRL;
            stride_q <= LPRR_RST_STRIDE;
        end else if (i_ce) begin
            start_q <= start_d;
            ctrl_q <= ctrl_d;
            stride_q <= stride_d;
        end
    end
    assign sh.act_start = start_q;
    assign sh.act_ctrl = ctrl_q;
    assign sh.act_stride = stride_q;
endmodule
`default_nettype wire

// file: logic/lprr_core.sv
// What this block does
// - Enable low: landscape, other fields ignored
// - Select bit: 0 default, 1 alternate
// - Default mode needs power-of-two width
// - Default mode scrolls in two-line steps
// - Alternate mode scrolls by one line
// - Alternate accepts any stride, e.g. 240
// - Start address is 17 bits, three registers
// - Portrait start is byte offset
// - Stride register gives line byte distance
// - Stride ignored in landscape
// - Memory clock boosted during CPU access
// - Input clock becomes portrait working clock
// - Refresh walks portrait image column-wise
// - No split screen in portrait
// - Control bit 2 makes memory clock equal input during CPU access and 16 ns after
// - Alternate: pixel clock is half memory clock
//
// Core: register port, frame shadow and rotated refresh address generator.
// Assumes synchronous byte-wide register strobes and a memory that accepts o_mem_addr each pixel strobe.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module lprr_core #(
    parameter int unsigned COLS = lprr_pkg::LPRR_PANEL_COLS,
    parameter int unsigned ROWS = lprr_pkg::LPRR_PANEL_ROWS
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_ce,
    // Register port
    input wire logic [lprr_pkg::LPRR_ADDR_W-1:0] i_reg_addr,
    input wire logic [lprr_pkg::LPRR_DATA_W-1:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [lprr_pkg::LPRR_DATA_W-1:0] o_reg_rdata,
    // CPU memory access in progress
    input wire logic i_cpu_access,
    // Refresh outputs
    output logic o_portrait,
    output logic o_alt_mode,
    output logic o_split_allowed,
    output logic o_pix_valid,
    output logic o_frame_start,
    output logic [lprr_pkg::LPRR_MADDR_W-1:0] o_mem_addr,
    output logic o_mclk_fast,
    output logic [1:0] o_pclk_sel
);
    import lprr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Register file
    logic [7:0] lo_q, lo_d, mid_q, mid_d, top_q, top_d, ctrl_q, ctrl_d, stride_q, stride_d;
    logic [7:0] rdata_q, rdata_d;

    always_comb begin
        lo_d = lo_q;
        mid_d = mid_q;
        top_d = top_q;
        ctrl_d = ctrl_q;
        stride_d = stride_q;
        rdata_d = 8'h00;
        if (i_reg_wr) begin
            case (i_reg_addr)
                LPRR_OFS_START_LO: lo_d = i_reg_wdata;
                LPRR_OFS_START_MID: mid_d = i_reg_wdata;
                LPRR_OFS_START_TOP: top_d = {7'h00, i_reg_wdata[0]};
                LPRR_OFS_ROT_CTRL: ctrl_d = i_reg_wdata & LPRR_CTRL_MASK;
                LPRR_OFS_STRIDE: stride_d = i_reg_wdata;
                default: ;
            endcase
        end
        if (i_reg_rd) begin
            case (i_reg_addr)
                LPRR_OFS_START_LO: rdata_d = lo_q;
                LPRR_OFS_START_MID: rdata_d = mid_q;
                LPRR_OFS_START_TOP: rdata_d = top_q;
                LPRR_OFS_ROT_CTRL: rdata_d = ctrl_q;
                LPRR_OFS_STRIDE: rdata_d = stride_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            lo_q <= LPRR_RST_START_LO;
            mid_q <= LPRR_RST_START_MID;
            top_q <= LPRR_RST_START_TOP;
            ctrl_q <= LPRR_RST_ROT_CTRL;
            stride_q <= LPRR_RST_STRIDE;
            rdata_q <= 8'h00;
        end else if (i_ce) begin
            lo_q <= lo_d;
            mid_q <= mid_d;
            top_q <= top_d;
            ctrl_q <= ctrl_d;
            stride_q <= stride_d;
            rdata_q <= rdata_d;
        end
    end
    assign o_reg_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Frame shadow
    lprr_shadow_if sh_if ();
    logic frame_start_q, frame_start_d;
    // Load on the wrap edge, together with the frame's first address
    assign sh_if.frame_start = frame_start_d;
    assign sh_if.live_start = {top_q[0], mid_q, lo_q};
    assign sh_if.live_ctrl = ctrl_q;
    assign sh_if.live_stride = stride_q;

    lprr_shadow u_shadow (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .sh(sh_if.dst)
    );

    logic act_en, act_alt, act_mclk;
    assign act_en = sh_if.act_ctrl[LPRR_BIT_ENABLE];
    assign act_alt = act_en & sh_if.act_ctrl[LPRR_BIT_ALT];
    assign act_mclk = act_en & sh_if.act_ctrl[LPRR_BIT_MCLK_SEL];

    // Round a stride up to a power of two for default mode
    function automatic logic [16:0] lprr_pow2(input logic [7:0] v);
        logic [16:0] r;
        r = 17'h00001;
        for (int i = 0; i < 8; i++) begin
            if (r < {9'h000, v}) begin
                r = {r[15:0], 1'b0};
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Rotated scan
    // Panel line = portrait column, walked from the right edge (B->D, down to A->C)
    localparam int unsigned CW = $clog2(COLS);
    localparam int unsigned RW = $clog2(ROWS);
    logic [CW-1:0] col_q, col_d;
    logic [RW-1:0] row_q, row_d;
    logic [16:0] addr_q, addr_d, line_base_q, line_base_d;
    logic phase_q, phase_d;
    logic valid_q, valid_d;
    logic [16:0] eff_stride, eff_start, next_start;

    // Frame stride: landscape ignores it, default rounds it up to a power of two
    function automatic logic [16:0] lprr_stride_of(input logic [7:0] st, input logic [7:0] c);
        logic [16:0] r;
        r = 17'h00000;
        if (c[LPRR_BIT_ENABLE] && c[LPRR_BIT_ALT]) begin
            r = {9'h000, st};
        end else if (c[LPRR_BIT_ENABLE]) begin
            r = lprr_pow2(st);
        end
        return r;
    endfunction

    // Frame start: landscape doubles the word offset, default drops the line-pair parity
    function automatic logic [16:0] lprr_start_of(input logic [16:0] s, input logic [7:0] st,
                                                  input logic [7:0] c);
        logic [16:0] r;
        r = {s[15:0], 1'b0};
        if (c[LPRR_BIT_ENABLE] && c[LPRR_BIT_ALT]) begin
            r = s;
        end else if (c[LPRR_BIT_ENABLE]) begin
            r = s & ~lprr_pow2(st);
        end
        return r;
    endfunction

    // Live values feed the wrap, so no pixel of a new frame uses stale settings
    assign eff_stride = lprr_stride_of(sh_if.act_stride, sh_if.act_ctrl);
    assign eff_start = lprr_start_of(sh_if.act_start, sh_if.act_stride, sh_if.act_ctrl);
    assign next_start = lprr_start_of(sh_if.live_start, sh_if.live_stride, sh_if.live_ctrl);

    always_comb begin
        col_d = col_q;
        row_d = row_q;
        addr_d = addr_q;
        line_base_d = line_base_q;
        frame_start_d = 1'b0;
        valid_d = 1'b0;
        phase_d = phase_q;
        // Alternate emits a pixel every other clock
        if (act_alt) begin
            phase_d = ~phase_q;
        end else begin
            phase_d = 1'b0;
        end
        if (!act_alt || phase_q) begin
            valid_d = 1'b1;
            if (col_q == CW'(COLS - 1)) begin
                col_d = '0;
                if (row_q == RW'(ROWS - 1)) begin
                    row_d = '0;
                    frame_start_d = 1'b1;
                    // Shadow loads on this same edge
                    line_base_d = next_start;
                    addr_d = next_start;
                end else begin
                    row_d = row_q + 1'b1;
                    // Next panel line is one byte left in the portrait image
                    line_base_d = act_en ? line_base_q - 17'h00001 : line_base_q + 17'(COLS);
                    addr_d = line_base_d;
                end
            end else begin
                col_d = col_q + 1'b1;
                // Down one portrait row per panel pixel
                addr_d = act_en ? addr_q + eff_stride : addr_q + 17'h00001;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            col_q <= '0;
            row_q <= '0;
            addr_q <= '0;
            line_base_q <= '0;
            phase_q <= 1'b0;
            valid_q <= 1'b0;
            frame_start_q <= 1'b0;
        end else if (i_ce) begin
            col_q <= col_d;
            row_q <= row_d;
            addr_q <= addr_d;
            line_base_q <= line_base_d;
            phase_q <= phase_d;
            valid_q <= valid_d;
            frame_start_q <= frame_start_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode and memory clock outputs
    localparam int unsigned HW = $clog2(LPRR_BOOST_HOLD_CYC + 1);
    logic [HW-1:0] hold_q, hold_d;
    logic fast_q, fast_d, port_q, alt_q, split_q;
    logic [1:0] pclk_q;

    always_comb begin
        hold_d = hold_q;
        if (act_mclk && i_cpu_access) begin
            hold_d = HW'(LPRR_BOOST_HOLD_CYC);
        end else if (hold_q != '0) begin
            hold_d = hold_q - 1'b1;
        end
        // Fast while accessing; alternate mode always runs memory at input clock
        fast_d = (act_mclk && (i_cpu_access || hold_q != '0)) || act_alt;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            hold_q <= '0;
            fast_q <= 1'b0;
            port_q <= 1'b0;
            alt_q <= 1'b0;
            split_q <= 1'b1;
            pclk_q <= 2'h0;
        end else if (i_ce) begin
            hold_q <= hold_d;
            fast_q <= fast_d;
            port_q <= act_en;
            alt_q <= act_alt;
            split_q <= ~act_en;
            pclk_q <= act_en ? sh_if.act_ctrl[LPRR_BIT_PCLK_HI:LPRR_BIT_PCLK_LO] : 2'h0;
        end
    end

    assign o_portrait = port_q;
    assign o_alt_mode = alt_q;
    assign o_split_allowed = split_q;
    assign o_pix_valid = valid_q;
    assign o_frame_start = frame_start_q;
    assign o_mem_addr = addr_q;
    assign o_mclk_fast = fast_q;
    assign o_pclk_sel = pclk_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    split_off_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_portrait |-> !o_split_allowed) else $error("split allowed in portrait");
    landscape_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !o_portrait |-> !o_alt_mode && o_pclk_sel == 2'h0) else $error("landscape shows portrait fields");
    alt_rate_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_ce && act_alt && o_pix_valid && $stable(act_alt)) |=> !o_pix_valid) else $error("alt pixel rate");
    def_rate_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_ce && $past(i_ce) && port_q && !act_alt && !o_alt_mode) |-> o_pix_valid) else $error("default rate");
    boost_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_ce && act_mclk && i_cpu_access && $stable(act_mclk)) |=> o_mclk_fast) else $error("no boost");
    no_boost_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_ce && !act_mclk && !act_alt && $stable(act_alt)) |=> !o_mclk_fast) else $error("boost while off");
    top_bit_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        top_q[7:1] == 7'h00) else $error("start top reserved bits");
    frame_load_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_frame_start |-> o_mem_addr == eff_start) else $error("frame start address");
    pow2_stride_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (act_en && !act_alt) |-> ((eff_stride & (eff_stride - 17'h00001)) == 17'h00000)
            && (eff_stride >= {9'h000, sh_if.act_stride})) else $error("default stride not power of two");
    pair_scroll_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (o_frame_start && act_en && !act_alt) |-> (o_mem_addr & eff_stride) == 17'h00000)
        else $error("default start on odd line");
    rdata_idle_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_ce && !i_reg_rd) |=> o_reg_rdata == 8'h00) else $error("read data outside read slot");
    resv_read_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_ce && i_reg_rd && i_reg_addr == LPRR_OFS_ROT_CTRL) |=> o_reg_rdata[5:3] == 3'h0)
        else $error("control reserved bits read back");
    ce_freeze_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !i_ce |=> $stable(o_mem_addr) && $stable(o_pix_valid) && $stable(o_frame_start))
        else $error("state moved while clock enable low");
    alt_fast_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_ce && act_alt) |=> o_mclk_fast) else $error("alt memory clock slow");

    // Pixels since the last frame start; the first frame after reset is short
    localparam int unsigned PW = $clog2(COLS * ROWS + 1);
    logic [PW-1:0] pix_cnt_q, pix_cnt_d;
    logic seen_frame_q, seen_frame_d;

    always_comb begin
        pix_cnt_d = pix_cnt_q;
        seen_frame_d = seen_frame_q;
        if (o_pix_valid && o_frame_start) begin
            pix_cnt_d = PW'(1);
            seen_frame_d = 1'b1;
        end else if (o_pix_valid) begin
            pix_cnt_d = pix_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            pix_cnt_q <= '0;
            seen_frame_q <= 1'b0;
        end else if (i_ce) begin
            pix_cnt_q <= pix_cnt_d;
            seen_frame_q <= seen_frame_d;
        end
    end

    frame_len_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (o_frame_start && seen_frame_q) |-> pix_cnt_q == PW'(COLS * ROWS)) else $error("frame length");
    cov_alt_c: cover property (@(posedge i_clk_sys) o_alt_mode && o_frame_start);
    cov_def_c: cover property (@(posedge i_clk_sys) o_portrait && !o_alt_mode && o_frame_start);
    cov_boost_c: cover property (@(posedge i_clk_sys) o_mclk_fast && !o_alt_mode);
    cov_land_c: cover property (@(posedge i_clk_sys) !o_portrait && o_frame_start && o_pix_valid);
    cov_freeze_c: cover property (@(posedge i_clk_sys) !i_ce && o_pix_valid);
endmodule
`default_nettype wire

// file: verification/lprr_panel_model.sv
// Panel model: watches the refresh stream, keeps the first addresses of each frame.
// Assumes one address per pixel strobe; a frame opens with the frame start pulse.
`timescale 1ns/1ps
`default_nettype none
module lprr_panel_model #(
    parameter int COLS = 4
) (
    // Clock
    input wire logic i_clk_sys,
    // Refresh stream
    input wire logic i_pix_valid,
    input wire logic i_frame_start,
    input wire logic [16:0] i_mem_addr,
    // Observations
    output logic [16:0] o_addr0,
    output logic [16:0] o_addr1,
    output logic [16:0] o_addrl,
    output logic [15:0] o_frame_pix,
    output logic [3:0] o_gap
);
    int idx = 0;
    int since = 0;
    ////////////////////////////////////////////////////////////////
    // Panel lines arrive as portrait columns, so only a few taps are kept
    always @(posedge i_clk_sys) begin
        since <= since + 1;
        if (i_pix_valid) begin
            since <= 1;
            o_gap <= 4'(since);
            if (i_frame_start) begin
                o_frame_pix <= 16'(idx);
                o_addr0 <= i_mem_addr;
                idx <= 1;
            end else begin
                idx <= idx + 1;
                if (idx == 1) o_addr1 <= i_mem_addr;
                if (idx == COLS) o_addrl <= i_mem_addr;
            end
        end
    end
endmodule
`default_nettype wire

// file: verification/lprr_core_test.sv
// Testbench: register traffic, mode table and refresh address checks for the rotation core.
// Assumes a tiny panel so frames stay short; the panel model taps the stream.
`timescale 1ns/1ps
`default_nettype none
module lprr_core_test;
    import lprr_pkg::*;
    localparam int COLS = 4;
    localparam int ROWS = 3;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic i_ce = 1'b1;
    logic [7:0] i_reg_addr = 8'h00;
    logic [7:0] i_reg_wdata = 8'h00;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic i_cpu_access = 1'b0;
    logic [7:0] o_reg_rdata;
    logic o_portrait, o_alt_mode, o_split_allowed, o_pix_valid, o_frame_start, o_mclk_fast;
    logic [16:0] o_mem_addr, o_addr0, o_addr1, o_addrl;
    logic [1:0] o_pclk_sel;
    logic [15:0] o_frame_pix;
    logic [3:0] o_gap;
    int err_total = 0;
    int checks_done = 0;
    int cyc = 0;
    logic [7:0] shadow [256];
    logic [7:0] pick [7] = '{8'h0C, 8'h0D, 8'h0E, 8'h1B, 8'h1C, 8'h1D, 8'h00};
    // Portrait starts are a whole number of (rounded) strides minus one, as software must load them; boost only at slow clocks
    logic [16:0] sc_start [7] = '{17'h10, 17'h7F, 17'hFF, 17'h17F, 17'h77, 17'hEF, 17'h1007F};
    logic [7:0] sc_stride [7] = '{8'h55, 8'h78, 8'h80, 8'h80, 8'h78, 8'h78, 8'h80};
    logic [7:0] sc_ctrl [7] = '{8'h47, 8'h80, 8'h84, 8'h80, 8'hC3, 8'hC1, 8'h82};

    lprr_core #(.COLS(COLS), .ROWS(ROWS)) DUT (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(i_ce),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .o_reg_rdata(o_reg_rdata), .i_cpu_access(i_cpu_access), .o_portrait(o_portrait),
        .o_alt_mode(o_alt_mode), .o_split_allowed(o_split_allowed), .o_pix_valid(o_pix_valid),
        .o_frame_start(o_frame_start), .o_mem_addr(o_mem_addr), .o_mclk_fast(o_mclk_fast),
        .o_pclk_sel(o_pclk_sel));
    lprr_panel_model #(.COLS(COLS)) panel (.i_clk_sys(i_clk_sys), .i_pix_valid(o_pix_valid),
        .i_frame_start(o_frame_start), .i_mem_addr(o_mem_addr), .o_addr0(o_addr0), .o_addr1(o_addr1),
        .o_addrl(o_addrl), .o_frame_pix(o_frame_pix), .o_gap(o_gap));

    always #4 i_clk_sys = ~i_clk_sys;
    ////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Hang guard, well above the fewer than one thousand cycles needed
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            end_sim();
        end
    end

    task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    function automatic logic [7:0] mask_of(input logic [7:0] a);
        case (a)
            8'h0C, 8'h0D, 8'h1C: return 8'hFF;
            8'h0E: return 8'h01;
            8'h1B: return 8'hC7;
            default: return 8'h00;
        endcase
    endfunction

    // Default mode rounds the stride up and drops the odd-line part of the start
    function automatic logic [16:0] exp_addr(input logic [16:0] s, input logic [7:0] st,
                                             input logic [7:0] c, input int ln, input int col);
        int p;
        p = 1;
        while (p < st) p = p * 2;
        if (!c[7]) return 17'(s * 2 + ln * COLS + col);
        if (c[6]) return 17'(s + col * st - ln);
        return 17'((s & ~17'(p)) + col * p - ln);
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_clk_sys);
        i_reg_wr <= 1'b0;
        shadow[a] = d;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge i_clk_sys);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_clk_sys);
        i_reg_rd <= 1'b0;
        @(negedge i_clk_sys);
        chk(17'(o_reg_rdata), 17'(shadow[a] & mask_of(a)));
    endtask

    task automatic wait_frame();
        int n;
        n = 0;
        @(negedge i_clk_sys);
        while (o_frame_start !== 1'b1 && n < 100) begin
            @(negedge i_clk_sys);
            n++;
        end
        if (n == 100) err_total++;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] a;
        logic [7:0] c;
        logic pt;
        logic prev;
        logic [16:0] held;
        void'($urandom(32'h2DFA));
        for (int i = 0; i < 256; i++) shadow[i] = 8'h00;
        repeat (16) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        foreach (pick[j]) rd(pick[j]);
        repeat (60) begin
            a = pick[$urandom_range(0, 6)];
            if ($urandom_range(0, 1) == 1) wr(a, 8'($urandom));
            else rd(a);
        end
        // Clock enable low: refresh frozen, a write strobe is ignored
        @(posedge i_clk_sys);
        i_ce <= 1'b0;
        i_reg_wr <= 1'b1;
        i_reg_addr <= LPRR_OFS_STRIDE;
        i_reg_wdata <= ~shadow[8'h1C];
        @(negedge i_clk_sys);
        held = o_mem_addr;
        @(posedge i_clk_sys);
        i_reg_wr <= 1'b0;
        repeat (6) @(negedge i_clk_sys);
        chk(o_mem_addr, held);
        @(posedge i_clk_sys);
        i_ce <= 1'b1;
        rd(LPRR_OFS_STRIDE);
        for (int k = 0; k < 7; k++) begin
            c = sc_ctrl[k];
            pt = c[7];
            wait_frame();
            prev = shadow[8'h1B][7];
            wr(LPRR_OFS_START_LO, sc_start[k][7:0]);
            wr(LPRR_OFS_START_MID, sc_start[k][15:8]);
            wr(LPRR_OFS_START_TOP, {7'h00, sc_start[k][16]});
            wr(LPRR_OFS_STRIDE, sc_stride[k]);
            wr(LPRR_OFS_ROT_CTRL, c);
            @(negedge i_clk_sys);
            chk(17'(o_portrait), 17'(prev));
            wait_frame();
            @(negedge i_clk_sys);
            chk(17'(o_portrait), 17'(pt));
            chk(17'(o_alt_mode), 17'(pt & c[6]));
            chk(17'(o_split_allowed), 17'(!pt));
            chk(17'(o_pclk_sel), pt ? 17'(c[1:0]) : 17'h0);
            @(posedge i_clk_sys);
            i_cpu_access <= 1'b1;
            repeat (2) @(posedge i_clk_sys);
            @(negedge i_clk_sys);
            chk(17'(o_mclk_fast), 17'(pt & (c[6] | c[2])));
            @(posedge i_clk_sys);
            i_cpu_access <= 1'b0;
            repeat (5) @(posedge i_clk_sys);
            @(negedge i_clk_sys);
            chk(17'(o_mclk_fast), 17'(pt & c[6]));
            wait_frame();
            repeat (2 * COLS + 4) @(negedge i_clk_sys);
            chk(o_addr0, exp_addr(sc_start[k], sc_stride[k], c, 0, 0));
            chk(o_addr1, exp_addr(sc_start[k], sc_stride[k], c, 0, 1));
            chk(o_addrl, exp_addr(sc_start[k], sc_stride[k], c, 1, 0));
            chk(17'(o_frame_pix), 17'(COLS * ROWS));
            chk(17'(o_gap), (pt & c[6]) ? 17'h2 : 17'h1);
        end
        end_sim();
    end
endmodule
`default_nettype wire
